/* File: src/rfid_frontend_command_sequencer.sv */
// How it works
// - Code 00h idles and ends running command.
// - Code 01h runs card detect, flags exceed.
// - After card detect, enter standby if selected.
// - Code 04h: query, ack, reqrn, replies to FIFO.
// - Code 05h receives until frame end.
// - Code 06h sends FIFO until empty.
// - Code 07h transmits then enables receiver.
// - Multiple-receive bit keeps transceive receiving until a new command.
// - Code 08h writes one EEPROM byte, waits data.
// - Byte write aborts beyond address 7Fh.
// - Code 09h writes up to 64 page bytes.
// - Page programming starts at 64 or empty.
// - Page write aborts: missing parameters, bad page, no data bytes.
// - Code 0Ah reads EEPROM, address wraps 1FFFh.
// - Read and load abort on bad parameters.
// - Code 0Ch copies EEPROM bytes into registers.
// - Code 0Dh loads protocol presets, aborts if missing.
// - Receive protocol numbers 0 to 7 valid.
// - Transmit protocol numbers 0 to 7 valid.
// - Code 1Ch fills FIFO with random bytes.
// - Code 1Fh reloads register defaults from EEPROM.
// - Sequencer returns command register to idle.
`default_nettype none

module rfid_frontend_command_sequencer
    import seq_pkg::*;
#(
    parameter int DEPTH = OUT_DEPTH
) (
    input  wire logic              mclk,           // System clock, 20 MHz.
    input  wire logic              rstn,           // Synchronous reset, active low.
    input  wire logic              cmd_wr,         // Host writes the command register.
    input  wire logic [7:0]        cmd_wdata,      // Command code written.
    output logic      [7:0]        cmd_value,      // Command register read value.
    output logic                   busy,           // A command is running.
    output logic                   cmd_done,       // Command ended normally.
    output logic                   cmd_abort,      // Command ended on a parameter error.
    input  wire logic              in_valid,       // Host FIFO holds a byte.
    output logic                   in_ready,       // Sequencer takes the byte.
    input  wire logic [7:0]        in_data,        // Host FIFO byte.
    output logic                   out_valid,      // Result byte for the host FIFO.
    input  wire logic              out_ready,      // Host FIFO accepts it.
    output logic      [7:0]        out_data,       // Result byte.
    input  wire logic              host_fifo_full, // Host FIFO is full.
    output logic                   tx_valid,       // Byte for the transmitter.
    input  wire logic              tx_ready,       // Transmitter takes it.
    output logic      [7:0]        tx_data,        // Transmit byte.
    output logic                   tx_gen,         // Link sends a generated frame.
    output logic      [1:0]        inv_phase,      // Inventory step being run.
    input  wire logic              tx_gen_done,    // Generated frame sent.
    output logic                   rx_en,          // Receive path enabled.
    input  wire logic              rx_valid,       // Received byte.
    output logic                   rx_ready,       // Received byte taken.
    input  wire logic [7:0]        rx_data,        // Received byte value.
    input  wire logic              rx_end,         // Received frame ended.
    input  wire logic [7:0]        rx_err_byte,    // Error flags of the last frame.
    input  wire logic              multiple_receive_bit, // Keep receiving.
    output logic                   cdet_start,     // Start card detection.
    input  wire logic              cdet_done,      // Card detection finished.
    input  wire logic              cdet_over,      // I or Q outside limits.
    output logic                   card_irq,       // Card-detect interrupt pulse.
    input  wire logic              standby_sel,    // Standby after card detection.
    output logic                   standby_req,    // Enter standby pulse.
    output logic                   ee_req,         // EEPROM access pulse.
    output logic                   ee_we,          // Access is a write.
    output logic                   ee_page,        // Write goes to the page latch.
    output logic                   ee_prog,        // Program the page latch.
    output logic      [EE_AW-1:0]  ee_addr,        // EEPROM address.
    output logic      [7:0]        ee_wdata,       // EEPROM write byte.
    input  wire logic              ee_done,        // EEPROM access finished.
    input  wire logic [7:0]        ee_rdata,       // EEPROM read byte.
    output logic                   reg_wr,         // Register set write pulse.
    output logic      [7:0]        target_register_address, // Register written.
    output logic      [7:0]        reg_wdata,      // Register write byte.
    output logic                   proto_req,      // Load protocol presets.
    output logic      [2:0]        proto_rx,       // Receive preset number.
    output logic      [2:0]        proto_tx,       // Transmit preset number.
    input  wire logic              proto_done,     // Presets loaded.
    input  wire logic [7:0]        rng_data,       // Random number byte.
    output logic                   sreset_req,     // Reload register defaults.
    input  wire logic              sreset_done     // Defaults reloaded.
);

    typedef struct packed {
        state_t             st;
        logic [7:0]         cmd;
        logic [3:0][7:0]    prm;
        logic [2:0]         pcnt;
        logic [EE_AW-1:0]   addr;
        logic [8:0]         cnt;
        logic [7:0]         radr;
        logic [7:0]         data;
        logic [1:0]         phase;
        logic               done;
        logic               abort;
        logic               cdet_start;
        logic               card_irq;
        logic               standby_req;
        logic               tx_gen;
        logic               ee_req;
        logic               ee_we;
        logic               ee_page;
        logic               ee_prog;
        logic [EE_AW-1:0]   ee_addr;
        logic [7:0]         ee_wdata;
        logic               reg_wr;
        logic [7:0]         reg_addr;
        logic [7:0]         reg_wdata;
        logic               proto_req;
        logic [2:0]         proto_rx;
        logic [2:0]         proto_tx;
        logic               sreset_req;
    } seq_t;

    seq_t       q;
    seq_t       d;
    logic       push_valid;
    logic       push_ready;
    logic [7:0] push_data;

    // Number of parameter bytes a command takes from the FIFO before it runs.
    function automatic logic [2:0] param_count(input logic [7:0] c);
        unique case (c)
            CMD_EE_BYTE: param_count = 3'd3;
            CMD_EE_PAGE: param_count = 3'd1;
            CMD_EE_READ: param_count = 3'd3;
            CMD_EE_LOAD: param_count = 3'd4;
            CMD_PROTO:   param_count = 3'd2;
            default:     param_count = 3'd0;
        endcase
    endfunction

    // First state of a command that needs no parameters.
    function automatic state_t start_state(input logic [7:0] c);
        unique case (c)
            CMD_CDET:      start_state = S_CDET;
            CMD_INVENTORY: start_state = S_INV_TX;
            CMD_RECEIVE:   start_state = S_RECV;
            CMD_TRANSMIT:  start_state = S_XMIT;
            CMD_TRANSCV:   start_state = S_XMIT;
            CMD_RANDOM:    start_state = S_RAND;
            CMD_SRESET:    start_state = S_SRESET;
            default:       start_state = S_IDLE;
        endcase
    endfunction

    // A read length of zero stands for the full block.
    function automatic logic [8:0] block_len(input logic [7:0] n);
        block_len = (n == 8'h00) ? LEN_ZERO_MEANS : {1'b0, n};
    endfunction

    always_comb begin
        d = q;
        d.done        = 1'b0;
        d.abort       = 1'b0;
        d.cdet_start  = 1'b0;
        d.card_irq    = 1'b0;
        d.standby_req = 1'b0;
        d.tx_gen      = 1'b0;
        d.ee_req      = 1'b0;
        d.ee_prog     = 1'b0;
        d.reg_wr      = 1'b0;
        d.proto_req   = 1'b0;
        d.sreset_req  = 1'b0;
        in_ready   = 1'b0;
        tx_valid   = 1'b0;
        rx_en      = 1'b0;
        rx_ready   = 1'b0;
        push_valid = 1'b0;
        push_data  = rx_data;

        unique case (q.st)
            S_IDLE: begin
            end
            S_PARAM: begin
                if (in_valid) begin
                    in_ready = 1'b1;
                    d.prm[q.pcnt[1:0]] = in_data;
                    d.pcnt = q.pcnt + 3'd1;
                    if (q.pcnt + 3'd1 == param_count(q.cmd)) begin
                        d.st = S_CHECK;
                    end
                end else if (q.cmd != CMD_EE_BYTE) begin
                    d.st = S_ABORT;
                end
            end
            S_CHECK: begin
                d.addr  = {q.prm[0][4:0], q.prm[1]};
                d.phase = 2'd0;
                unique case (q.cmd)
                    CMD_EE_BYTE: begin
                        if ({q.prm[0], q.prm[1]} > BYTE_WR_ADDR_MAX) begin
                            d.st = S_ABORT;
                        end else begin
                            d.ee_req   = 1'b1;
                            d.ee_we    = 1'b1;
                            d.ee_page  = 1'b0;
                            d.ee_addr  = EE_AW'(q.prm[1]);
                            d.ee_wdata = q.prm[2];
                            d.st       = S_EEWAIT;
                        end
                    end
                    CMD_EE_PAGE: begin
                        if (q.prm[0] > PAGE_ADDR_MAX) begin
                            d.st = S_ABORT;
                        end else begin
                            d.addr = {q.prm[0][6:0], 6'h00};
                            d.cnt  = '0;
                            d.st   = S_PAGE;
                        end
                    end
                    CMD_EE_READ, CMD_EE_LOAD: begin
                        if ({q.prm[0], q.prm[1]} > EE_ADDR_MAX) begin
                            d.st = S_ABORT;
                        end else begin
                            d.radr = q.prm[2];
                            d.cnt  = block_len((q.cmd == CMD_EE_READ) ? q.prm[2] : q.prm[3]);
                            d.st   = S_RD;
                        end
                    end
                    default: begin
                        if (q.prm[0] > PROTO_NUM_MAX || q.prm[1] > PROTO_NUM_MAX) begin
                            d.st = S_ABORT;
                        end else begin
                            d.proto_rx  = q.prm[0][2:0];
                            d.proto_tx  = q.prm[1][2:0];
                            d.proto_req = 1'b1;
                            d.st        = S_PROTO;
                        end
                    end
                endcase
            end
            S_CDET: begin
                if (cdet_done) begin
                    d.card_irq = cdet_over;
                    d.standby_req = standby_sel;
                    d.st = S_DONE;
                end
            end
            S_XMIT: begin
                tx_valid = in_valid;
                in_ready = tx_ready;
                if (!in_valid) begin
                    d.st = (q.cmd == CMD_TRANSCV) ? S_RECV : S_DONE;
                end
            end
            S_RECV: begin
                rx_en      = 1'b1;
                push_valid = rx_valid;
                rx_ready   = push_ready;
                if (rx_end && !(q.cmd == CMD_TRANSCV && multiple_receive_bit)) begin
                    d.st = S_DONE;
                end
            end
            S_INV_TX: begin
                tx_valid = in_valid;
                in_ready = tx_ready;
                if (!in_valid) begin
                    d.st = S_INV_RX;
                end
            end
            S_INV_GEN: begin
                if (tx_gen_done) begin
                    d.st = S_INV_RX;
                end
            end
            S_INV_RX: begin
                rx_en      = 1'b1;
                push_valid = rx_valid;
                rx_ready   = push_ready;
                if (rx_end) begin
                    d.st = S_INV_ERR;
                end
            end
            S_INV_ERR: begin
                push_valid = 1'b1;
                push_data  = rx_err_byte;
                if (push_ready) begin
                    d.phase = q.phase + 2'd1;
                    d.tx_gen = (q.phase != INV_LAST_PHASE);
                    d.st = (q.phase == INV_LAST_PHASE) ? S_DONE : S_INV_GEN;
                end
            end
            S_EEWAIT: begin
                if (ee_done) begin
                    d.data = ee_rdata;
                    if (q.cmd == CMD_EE_PAGE && q.phase == 2'd0) begin
                        d.cnt = q.cnt + 9'd1;
                        d.st  = S_PAGE;
                    end else if (q.cmd == CMD_EE_READ || q.cmd == CMD_EE_LOAD) begin
                        d.st = S_PUSH;
                    end else begin
                        d.st = S_DONE;
                    end
                end
            end
            S_PAGE: begin
                if (q.cnt == PAGE_BYTES || !in_valid) begin
                    if (q.cnt == '0) begin
                        d.st = S_ABORT;
                    end else begin
                        d.ee_prog = 1'b1;
                        d.phase   = 2'd1;
                        d.st      = S_EEWAIT;
                    end
                end else begin
                    in_ready   = 1'b1;
                    d.ee_req   = 1'b1;
                    d.ee_we    = 1'b1;
                    d.ee_page  = 1'b1;
                    d.ee_addr  = q.addr | EE_AW'(q.cnt[5:0]);
                    d.ee_wdata = in_data;
                    d.st       = S_EEWAIT;
                end
            end
            S_RD: begin
                d.ee_req  = 1'b1;
                d.ee_we   = 1'b0;
                d.ee_page = 1'b0;
                d.ee_addr = q.addr;
                d.st      = S_EEWAIT;
            end
            S_PUSH: begin
                push_valid = (q.cmd == CMD_EE_READ);
                push_data  = q.data;
                if (q.cmd == CMD_EE_LOAD || push_ready) begin
                    if (q.cmd == CMD_EE_LOAD) begin
                        d.reg_wr    = 1'b1;
                        d.reg_addr  = q.radr;
                        d.reg_wdata = q.data;
                        d.radr      = q.radr + 8'd1;
                    end
                    d.addr = q.addr + EE_AW'(1);
                    d.cnt  = q.cnt - 9'd1;
                    d.st   = (q.cnt == 9'd1) ? S_DONE : S_RD;
                end
            end
            S_PROTO: begin
                if (proto_done) begin
                    d.st = S_DONE;
                end
            end
            S_RAND: begin
                push_valid = !host_fifo_full;
                push_data  = rng_data;
                if (host_fifo_full) begin
                    d.st = S_DONE;
                end
            end
            S_SRESET: begin
                if (sreset_done) begin
                    d.st = S_DONE;
                end
            end
            S_DONE: begin
                d.cmd  = CMD_IDLE;
                d.done = !cmd_wr;
                d.st   = S_IDLE;
            end
            S_ABORT: begin
                d.cmd   = CMD_IDLE;
                d.abort = !cmd_wr;
                d.st    = S_IDLE;
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase

        // A host write always wins: whatever runs is dropped at once.
        // terminate on new command
        if (cmd_wr) begin
            d.cmd        = cmd_wdata;
            d.pcnt       = 3'd0;
            d.phase      = 2'd0;
            d.cdet_start = (cmd_wdata == CMD_CDET);
            d.sreset_req = (cmd_wdata == CMD_SRESET);
            d.st = (param_count(cmd_wdata) != 3'd0) ? S_PARAM : start_state(cmd_wdata);
            // Unknown codes behave as idle so the register never shows a stale code.
            if (d.st == S_IDLE) begin
                d.cmd = CMD_IDLE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q     <= '0;
            q.st  <= S_IDLE;
            q.cmd <= CMD_IDLE;
        end else begin
            q <= d;
        end
    end

    seq_out_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_out (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    assign cmd_value   = q.cmd;
    assign busy        = (q.st != S_IDLE);
    assign cmd_done    = q.done;
    assign cmd_abort   = q.abort;
    assign tx_data     = in_data;
    assign tx_gen      = q.tx_gen;
    assign inv_phase   = q.phase;
    assign cdet_start  = q.cdet_start;
    assign card_irq    = q.card_irq;
    assign standby_req = q.standby_req;
    assign ee_req      = q.ee_req;
    assign ee_we       = q.ee_we;
    assign ee_page     = q.ee_page;
    assign ee_prog     = q.ee_prog;
    assign ee_addr     = q.ee_addr;
    assign ee_wdata    = q.ee_wdata;
    assign reg_wr      = q.reg_wr;
    assign target_register_address = q.reg_addr;
    assign reg_wdata   = q.reg_wdata;
    assign proto_req   = q.proto_req;
    assign proto_rx    = q.proto_rx;
    assign proto_tx    = q.proto_tx;
    assign sreset_req  = q.sreset_req;

endmodule // rfid_frontend_command_sequencer

`default_nettype wire

/* File: src/seq_pkg.sv */
`default_nettype none

package seq_pkg;

    // Command codes as written to the command register.
    localparam logic [7:0] CMD_IDLE      = 8'h00;
    localparam logic [7:0] CMD_CDET      = 8'h01;
    localparam logic [7:0] CMD_INVENTORY = 8'h04;
    localparam logic [7:0] CMD_RECEIVE   = 8'h05;
    localparam logic [7:0] CMD_TRANSMIT  = 8'h06;
    localparam logic [7:0] CMD_TRANSCV   = 8'h07;
    localparam logic [7:0] CMD_EE_BYTE   = 8'h08;
    localparam logic [7:0] CMD_EE_PAGE   = 8'h09;
    localparam logic [7:0] CMD_EE_READ   = 8'h0A;
    localparam logic [7:0] CMD_EE_LOAD   = 8'h0C;
    localparam logic [7:0] CMD_PROTO     = 8'h0D;
    localparam logic [7:0] CMD_RANDOM    = 8'h1C;
    localparam logic [7:0] CMD_SRESET    = 8'h1F;

    // Parameter limits.
    localparam logic [15:0] BYTE_WR_ADDR_MAX = 16'h007F;
    localparam logic [7:0]  PAGE_ADDR_MAX    = 8'h7F;
    localparam logic [15:0] EE_ADDR_MAX      = 16'h1FFF;
    localparam logic [7:0]  PROTO_NUM_MAX    = 8'h07;

    // Page geometry, block lengths and the last inventory phase.
    localparam logic [8:0]  PAGE_BYTES       = 9'h040;
    localparam logic [8:0]  LEN_ZERO_MEANS   = 9'h100;
    localparam logic [1:0]  INV_LAST_PHASE   = 2'h2;

    // Widths and buffer geometry.
    localparam int EE_AW      = 13;
    localparam int OUT_DEPTH  = 4;

    typedef enum logic [4:0] {
        S_IDLE, S_PARAM, S_CHECK, S_CDET, S_XMIT, S_RECV, S_INV_TX, S_INV_GEN,
        S_INV_RX, S_INV_ERR, S_EEWAIT, S_PAGE, S_RD, S_PUSH, S_PROTO,
        S_RAND, S_SRESET, S_DONE, S_ABORT
    } state_t;

endpackage

`default_nettype wire

/* File: src/seq_out_fifo.sv */
`default_nettype none

module seq_out_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,      // System clock.
    input  wire logic             rstn,      // Synchronous reset, active low.
    input  wire logic             in_valid,  // Write side offers a word.
    output logic                  in_ready,  // Room for a word.
    input  wire logic [WIDTH-1:0] in_data,   // Word to store.
    output logic                  out_valid, // A word is waiting.
    input  wire logic             out_ready, // Reader takes the word.
    output logic      [WIDTH-1:0] out_data   // Oldest word.
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_t;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_t            q;
    fifo_t            d;
    logic             push;
    logic             pop;

    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
        if (push) begin
            mem[q.wp] <= in_data;
        end
    end

endmodule // seq_out_fifo

`default_nettype wire

/* File: tb/seq_far_model.sv */
`default_nettype none
module seq_far_model import seq_pkg::*; (
    input  wire logic mclk, rstn, ee_req, proto_req, sreset_req, cdet_start, tx_gen, // Requests.
    input  wire logic ee_prog, // Program.
    input  wire logic [EE_AW-1:0] ee_addr, // EEPROM address.
    output logic ee_done, proto_done, sreset_done, cdet_done, tx_gen_done, // Replies.
    output logic [7:0] ee_rdata // EEPROM byte.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] req_q, mid_q;
    always_ff @(posedge mclk) begin
        req_q <= rstn ? {ee_req | ee_prog, proto_req, sreset_req, cdet_start, tx_gen} : 5'h00;
        mid_q <= rstn ? req_q : 5'h00;
    end
    assign {ee_done, proto_done, sreset_done, cdet_done, tx_gen_done} = mid_q;
    // Outside ee_done the bus shows the inverse, so late samples fail.
    assign ee_rdata = ee_done ? (ee_addr[7:0] ^ 8'hA5) : ~(ee_addr[7:0] ^ 8'hA5);
endmodule // seq_far_model
`default_nettype wire

/* File: tb/seq_sva.sv */
`default_nettype none
module seq_sva import seq_pkg::*; (
    input wire logic mclk, rstn, cmd_wr, busy, cmd_done, in_valid, tx_valid, // Control.
    input wire logic [7:0] cmd_wdata, cmd_value, // Command register.
    input wire logic sreset_req, cdet_start, cdet_done, cdet_over, card_irq, // Side jobs.
    input wire logic standby_sel, standby_req, // Standby.
    input wire logic ee_req, ee_we, ee_page, rx_en, multiple_receive_bit, cmd_abort, // Paths.
    input wire logic [EE_AW-1:0] ee_addr // EEPROM address.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_idle; cmd_wr && cmd_wdata == CMD_IDLE |=> !busy && cmd_value == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle write left a command running");
    property p_cdet; cmd_wr && cmd_wdata == CMD_CDET |=> cdet_start ##1 !cdet_start; endproperty
    a_cdet: assert property (p_cdet) else $error("card detect not started");
    property p_card; cdet_done && busy && cmd_value == CMD_CDET |=> card_irq == $past(cdet_over)
        && standby_req == $past(standby_sel); endproperty
    a_card: assert property (p_card) else $error("card interrupt wrong");
    property p_tx; busy && cmd_value == CMD_TRANSMIT |-> tx_valid == in_valid; endproperty
    a_tx: assert property (p_tx) else $error("transmit stream not passed");
    property p_rxm; rx_en && multiple_receive_bit && cmd_value == CMD_TRANSCV && !cmd_wr |=> rx_en;
    endproperty
    a_rxm: assert property (p_rxm) else $error("multiple receive ended");
    property p_bwr; ee_req && ee_we && !ee_page |-> ee_addr <= 13'h007F; endproperty
    a_bwr: assert property (p_bwr) else $error("byte write out of range");
    property p_srst; cmd_wr && cmd_wdata == CMD_SRESET |=> sreset_req && busy; endproperty
    a_srst: assert property (p_srst) else $error("soft reset not requested");
    property p_done; cmd_done |-> cmd_value == 8'h00 && !busy; endproperty
    a_done: assert property (p_done) else $error("command register not returned");
    c_abort: cover property (cmd_abort);
    c_card: cover property (card_irq);
    c_rxm: cover property (rx_en && multiple_receive_bit);
endmodule // seq_sva
bind rfid_frontend_command_sequencer seq_sva chk_u (.mclk, .rstn, .cmd_wr, .busy, .cmd_done,
    .in_valid, .tx_valid, .cmd_wdata, .cmd_value, .sreset_req, .cdet_start, .cdet_done,
    .cdet_over, .card_irq, .ee_req, .ee_we, .ee_page, .rx_en, .multiple_receive_bit,
    .cmd_abort, .ee_addr, .standby_sel, .standby_req);
`default_nettype wire

/* File: tb/rfid_frontend_command_sequencer_tb.sv */
`default_nettype none
module rfid_frontend_command_sequencer_tb;
    import seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rstn = 0, cmd_wr = 0, busy, cmd_done, cmd_abort, in_valid = 0, in_ready;
    logic out_valid, out_ready = 1, host_fifo_full = 0, tx_valid, tx_ready = 1, tx_gen, tx_gen_done;
    logic rx_en, rx_valid = 0, rx_ready, rx_end = 0, multiple_receive_bit = 0, cdet_start, cdet_done;
    logic cdet_over = 0, card_irq, standby_sel = 0, standby_req, ee_req, ee_we, ee_page, ee_prog;
    logic ee_done, reg_wr, proto_req, proto_done, sreset_req, sreset_done;
    logic [7:0] cmd_wdata = 0, cmd_value, in_data = 0, out_data, tx_data, rx_data = 0, rng_data = 0;
    logic [7:0] rx_err_byte = 0, target_register_address, reg_wdata, ee_rdata, ee_wdata;
    logic [1:0] inv_phase;
    logic [2:0] proto_rx, proto_tx;
    logic [EE_AW-1:0] ee_addr;
    int num_errors = 0, compares = 0, cyc = 0, a;
    logic [7:0] in_q[$], got_q[$];
    rfid_frontend_command_sequencer dut_u (.*);
    seq_far_model far_u (.*);
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (in_valid && in_ready) void'(in_q.pop_front());
        in_valid <= in_q.size() > 0;
        in_data <= in_q.size() > 0 ? in_q[0] : ~in_data;
        {rng_data, rx_data, rx_err_byte, cdet_over, standby_sel} <= 26'($urandom);
        if (out_valid) got_q.push_back(out_data);
        if (cyc > 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] code);
        @(posedge mclk) {cmd_wr, cmd_wdata} <= {1'b1, code};
        @(posedge mclk) cmd_wr <= 1'b0;
    endtask
    task automatic run(input logic [7:0] code, input int n, input logic [31:0] p, input logic ab);
        int t;
        @(negedge mclk);
        in_q.delete();
        for (int i = n - 1; i >= 0; i--) in_q.push_back(p[8*i +: 8]);
        repeat (2) @(posedge mclk);
        wr(code);
        for (t = 0; t < 600 && !(cmd_done || cmd_abort); t++) @(posedge mclk);
        chk("end", {6'h00, ~ab, ab}, {6'h00, cmd_done, cmd_abort});
    endtask
    task automatic results();
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        void'($urandom(1146));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        run(CMD_EE_BYTE, 3, {16'h0000, 8'h7F, 8'($urandom)}, 1'b0);
        run(CMD_EE_BYTE, 3, {16'h0000, 8'h80, 8'h11}, 1'b1);
        run(CMD_EE_PAGE, 3, {8'h00, 8'h05, 8'($urandom), 8'h55}, 1'b0);
        run(CMD_EE_PAGE, 2, {16'h0000, 8'h80, 8'h01}, 1'b1);
        got_q.delete();
        run(CMD_EE_READ, 3, {8'h00, 8'h1F, 8'hFF, 8'h02}, 1'b0);
        repeat (6) @(posedge mclk);
        chk("count", 8'h02, 8'(got_q.size()));
        a = 'h1FFF;
        for (int i = 0; i < 2; i++) begin
            chk("read", 8'(a) ^ 8'hA5, got_q[i]);
            a = (a + 1) % 8192;
        end
        run(CMD_EE_LOAD, 3, {8'h00, 8'h20, 8'h00, 8'h10}, 1'b1);
        run(CMD_PROTO, 2, {16'h0000, 8'h07, 8'h00}, 1'b0);
        run(CMD_PROTO, 1, {24'h00_0000, 8'h01}, 1'b1);
        run(CMD_SRESET, 0, 0, 1'b0);
        run(CMD_CDET, 0, 0, 1'b0);
        run(CMD_TRANSMIT, 2, {16'h0000, 8'($urandom), 8'h3C}, 1'b0);
        multiple_receive_bit <= 1'b1;
        @(negedge mclk) in_q.push_back(8'h42);
        wr(CMD_TRANSCV);
        repeat (8) @(posedge mclk);
        rx_end <= 1'b1;
        @(posedge mclk) rx_end <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("rx_en", 8'h01, {7'h00, rx_en});
        wr(CMD_IDLE);
        @(posedge mclk);
        chk("busy", 8'h00, {7'h00, busy});
        results();
    end
endmodule // rfid_frontend_command_sequencer_tb
`default_nettype wire
